/* dv/duart_bus_monitor.sv */
`timescale 1ns/1ps
module duart_bus_monitor (
  input wire logic             I_CORE_CLK,
  input wire logic             I_SRST,
  input wire logic             bus_style,
  input wire logic             read_strobe_n,
  input wire logic             write_strobe_n,
  input wire logic             channel_a_select_n,
  input wire logic             channel_b_select_n,
  input wire logic             host_data_oe,
  input wire duart_pkg::byte_t dev_data,
  input wire logic             dev_data_oe,
  input wire logic             channel_a_irq,
  input wire logic             channel_a_irq_oe,
  input wire logic             channel_b_irq_oe
);
  import duart_pkg::*;

  logic [2:0] style_age;
  logic       prev_style;
  logic       sel_idle;

  // Cycles since the strap last moved, so style checks skip the resync window.
  always_ff @(posedge I_CORE_CLK) begin
    prev_style <= bus_style;
    if (I_SRST || bus_style != prev_style) begin
      style_age <= 3'h0;
    end else if (style_age != 3'h7) begin
      style_age <= style_age + 3'h1;
    end
  end

  assign sel_idle = bus_style ? (channel_a_select_n && channel_b_select_n) : channel_a_select_n;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  bus_no_fight_a: assert property (!(dev_data_oe && host_data_oe))
    else $error("data bus driven by both ends");
  read_drive_sep_a: assert property ((bus_style && $rose(dev_data_oe)) |->
    (!read_strobe_n && !(channel_a_select_n && channel_b_select_n)))
    else $error("device drove data without a selected read strobe");
  read_drive_rw_a: assert property ((!bus_style && $rose(dev_data_oe)) |->
    (!channel_a_select_n && write_strobe_n))
    else $error("device drove data without a selected read cycle");
  read_answer_a: assert property (($fell(read_strobe_n) && bus_style &&
    !(channel_a_select_n && channel_b_select_n)) |-> ##[2:4] dev_data_oe)
    else $error("read strobe got no data drive");
  rw_answer_a: assert property (($fell(channel_a_select_n) && !bus_style &&
    write_strobe_n && style_age == 3'h7) |-> ##[2:4] dev_data_oe)
    else $error("select with read direction got no data drive");
  data_hold_a: assert property ((dev_data_oe && $past(dev_data_oe)) |->
    $stable(dev_data))
    else $error("read byte changed while driven");
  no_write_drive_a: assert property (dev_data_oe |-> write_strobe_n)
    else $error("device drove data during a write");
  sel_release_a: assert property (sel_idle [*5] |=> !dev_data_oe)
    else $error("data still driven long after deselect");
  od_low_only_a: assert property ((!bus_style && style_age == 3'h7 &&
    channel_a_irq_oe) |-> !channel_a_irq)
    else $error("shared interrupt driven high");
  b_irq_idle_a: assert property ((!bus_style && style_age == 3'h7) |->
    !channel_b_irq_oe)
    else $error("channel b interrupt driven in shared style");

  cover property (bus_style && $rose(dev_data_oe));
  cover property (!bus_style && $rose(dev_data_oe));
  cover property (!bus_style && channel_a_irq_oe);
  cover property (bus_style && channel_a_irq_oe && channel_a_irq);
endmodule // duart_bus_monitor

/* dv/testbench.sv */
`timescale 1ns/1ps
`include "duart_consts.svh"
module testbench;
  import duart_pkg::*;

  typedef struct packed {
    logic      style;
    logic      wr;
    logic      ch;
    reg_addr_t a;
    byte_t     d;
  } row_s;

  logic        core_clk, srst, bus_style_sel, req, write_en, channel_sel;
  logic        ready, done, irq_a, irq_b, sleep_osc, sleep_pump, power_save, wake;
  logic        osc_stop, pump_stop, wake_irq, reg_write, reg_channel;
  logic [1:0]  chan_irq;
  reg_addr_t   addr_sel, reg_addr;
  byte_t       wdata, rdata, reg_wdata;
  power_mode_e power_mode;
  int          err_total, checks_done, wr_seen, cycles, n0;
  row_s        rows [8] = '{
    '{1'h1, 1'h1, 1'h0, 3'h0, 8'ha5}, '{1'h1, 1'h1, 1'h1, 3'h0, 8'h5a},
    '{1'h1, 1'h0, 1'h0, 3'h0, 8'ha5}, '{1'h0, 1'h0, 1'h1, 3'h0, 8'h5a},
    '{1'h0, 1'h1, 1'h0, 3'h2, 8'h3c}, '{1'h0, 1'h1, 1'h1, 3'h6, 8'hc3},
    '{1'h1, 1'h0, 1'h0, 3'h2, 8'h3c}, '{1'h0, 1'h0, 1'h1, 3'h6, 8'hc3}};

  duart_bus_if bus_if ();

  duart_host_port #(.SETUP_CYC(1), .STROBE_CYC(6), .HOLD_CYC(3)) duart_host_port_inst (
    .I_CORE_CLK(core_clk), .I_SRST(srst), .bus(bus_if.host), .I_BUS_STYLE(bus_style_sel),
    .I_REQ(req), .I_WRITE(write_en), .I_CHANNEL(channel_sel), .I_ADDR(addr_sel),
    .I_WDATA(wdata), .O_READY(ready), .O_DONE(done), .O_RDATA(rdata), .O_IRQ_A(irq_a),
    .O_IRQ_B(irq_b));

  duart_device_port duart_device_port_inst (
    .I_CORE_CLK(core_clk), .I_SRST(srst), .bus(bus_if.dev), .I_CHANNEL_IRQ(chan_irq),
    .I_SLEEP_OSC(sleep_osc), .I_SLEEP_PUMP(sleep_pump), .I_POWER_SAVE(power_save),
    .I_WAKE(wake), .O_OSC_STOP(osc_stop), .O_PUMP_STOP(pump_stop), .O_POWER_MODE(power_mode),
    .O_WAKE_IRQ(wake_irq), .O_REG_WRITE(reg_write), .O_REG_CHANNEL(reg_channel),
    .O_REG_ADDR(reg_addr), .O_REG_WDATA(reg_wdata));

  duart_bus_monitor duart_bus_monitor_inst (
    .I_CORE_CLK(core_clk), .I_SRST(srst), .bus_style(bus_if.bus_style),
    .read_strobe_n(bus_if.read_strobe_n), .write_strobe_n(bus_if.write_strobe_n),
    .channel_a_select_n(bus_if.channel_a_select_n),
    .channel_b_select_n(bus_if.channel_b_select_n), .host_data_oe(bus_if.host_data_oe),
    .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe),
    .channel_a_irq(bus_if.channel_a_irq), .channel_a_irq_oe(bus_if.channel_a_irq_oe),
    .channel_b_irq_oe(bus_if.channel_b_irq_oe));

  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (srst) wr_seen <= 0;
    else if (reg_write === 1'h1) wr_seen <= wr_seen + 1;
    if (cycles == 6000) begin
      err_total++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'h1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge core_clk);
    #1;
  endtask

  task automatic set_style(input logic s);
    @(posedge core_clk);
    bus_style_sel <= s;
    settle();
  endtask

  // Pins in order: power-save, oscillator sleep, pump sleep, wake.
  task automatic set_pins(input logic [3:0] p);
    @(posedge core_clk);
    {power_save, sleep_osc, sleep_pump, wake} <= p;
    settle();
  endtask

  task automatic xfer(input logic wr, input logic ch, input reg_addr_t a, input byte_t d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= 1'h1;
    write_en <= wr;
    channel_sel <= ch;
    addr_sel <= a;
    wdata <= d;
    @(posedge core_clk);
    req <= 1'h0;
    #1;
    while (done !== 1'h1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(n < 40, "bus cycle never completed");
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  initial begin
    {srst, bus_style_sel, req, write_en, channel_sel} = 5'b11000;
    {sleep_osc, sleep_pump, power_save, wake, chan_irq} = 6'h00;
    addr_sel = 3'h0;
    wdata = 8'h00;
    {err_total, checks_done, wr_seen, cycles} = 128'h0;
    repeat (2) @(posedge core_clk);
    srst <= 1'h0;
    foreach (rows[i]) begin
      set_style(rows[i].style);
      n0 = wr_seen;
      xfer(rows[i].wr, rows[i].ch, rows[i].a, rows[i].d);
      if (rows[i].wr) begin
        check(wr_seen == n0 + 1 && reg_channel === rows[i].ch &&
              reg_addr === rows[i].a && reg_wdata === rows[i].d, "register write");
      end else begin
        check(rdata === rows[i].d && wr_seen == n0, "register read");
      end
    end
    $display("table test done");
    for (int i = 0; i < 8; i++) xfer(1'h1, 1'h1, reg_addr_t'(i), byte_t'(8'h10 + i));
    for (int i = 0; i < 8; i++) begin
      xfer(1'h0, 1'h1, reg_addr_t'(i), 8'h00);
      check(rdata === byte_t'(8'h10 + i), "address sweep readback");
    end
    $display("address test done");
    @(posedge core_clk);
    srst <= 1'h1;
    repeat (4) @(posedge core_clk);
    srst <= 1'h0;
    bus_style_sel <= 1'h1;
    settle();
    check(power_mode === PWR_ACTIVE && ready === 1'h1 && wake_irq === 1'h0 &&
          osc_stop === 1'h0, "reset state");
    xfer(1'h0, 1'h1, 3'h5, 8'h00);
    check(rdata === 8'h00, "register not cleared by reset");
    $display("reset test done");
    xfer(1'h1, 1'h0, `DUART_REG_MODEM, 8'h08);
    @(posedge core_clk);
    chan_irq <= 2'b11;
    settle();
    check(irq_a === 1'h1 && irq_b === 1'h0, "separate interrupt gating");
    xfer(1'h1, 1'h0, `DUART_REG_MODEM, 8'h00);
    check(irq_a === 1'h0, "interrupt not released by control bit");
    @(posedge core_clk);
    chan_irq <= 2'b10;
    set_style(1'h0);
    check(irq_a === 1'h1 && irq_b === 1'h0,
          "shared interrupt from channel b");
    @(posedge core_clk);
    chan_irq <= 2'b00;
    settle();
    check(irq_a === 1'h0, "shared interrupt not released");
    $display("interrupt test done");
    set_style(1'h1);
    xfer(1'h1, 1'h0, `DUART_REG_PWR, 8'h01);
    check(power_mode === PWR_PARTIAL && osc_stop === 1'h1 &&
          pump_stop === 1'h0, "software partial sleep");
    xfer(1'h1, 1'h0, `DUART_REG_PWR, 8'h03);
    check(power_mode === PWR_FULL && osc_stop === 1'h1 &&
          pump_stop === 1'h1, "software full sleep");
    xfer(1'h1, 1'h0, `DUART_REG_PWR, 8'h00);
    check(power_mode === PWR_ACTIVE && wake_irq === 1'h1,
          "no wake interrupt on exit");
    xfer(1'h0, 1'h0, `DUART_REG_PWR, 8'h00);
    check(rdata === 8'h80, "wake flag readback");
    set_pins(4'b0010);
    check(power_mode === PWR_PARTIAL && pump_stop === 1'h1 &&
          osc_stop === 1'h0, "pin partial sleep");
    set_pins(4'b0110);
    check(power_mode === PWR_FULL, "pin full sleep");
    set_pins(4'b1110);
    check(power_mode === PWR_SAVE, "pin power save");
    n0 = wr_seen;
    xfer(1'h1, 1'h1, 3'h1, 8'h77);
    check(wr_seen == n0, "write accepted while isolated");
    set_pins(4'b0000);
    check(power_mode === PWR_ACTIVE && wake_irq === 1'h1, "pin exit without wake");
    xfer(1'h0, 1'h1, 3'h1, 8'h00);
    check(rdata === 8'h00, "isolated write landed");
    xfer(1'h1, 1'h0, `DUART_REG_PWR, 8'h03);
    set_pins(4'b0001);
    check(power_mode === PWR_ACTIVE, "wake pin did not end sleep");
    set_pins(4'b0000);
    $display("power test done");
    give_verdict();
  end
endmodule // testbench

/* src/duart_bus_if.sv */
`timescale 1ns/1ps
interface duart_bus_if;
  import duart_pkg::*;

  logic       bus_style;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       channel_a_select_n;
  logic       channel_b_select_n;
  reg_addr_t  addr;
  byte_t      host_data;
  logic       host_data_oe;
  byte_t      dev_data;
  logic       dev_data_oe;
  logic       channel_a_irq;
  logic       channel_a_irq_oe;
  logic       channel_b_irq;
  logic       channel_b_irq_oe;

  // Resolved wire levels: undriven data floats high, undriven irq lines read
  // low in separate-strobe style; the shared open-drain line has a pull-up.
  byte_t      data_line;
  logic       irq_a_line;
  logic       irq_b_line;

  assign data_line  = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hff);
  assign irq_a_line = channel_a_irq_oe ? channel_a_irq : ~bus_style;
  assign irq_b_line = channel_b_irq_oe ? channel_b_irq : 1'h0;

  modport dev (
    input  bus_style, read_strobe_n, write_strobe_n, channel_a_select_n,
    input  channel_b_select_n, addr, data_line,
    output dev_data, dev_data_oe, channel_a_irq, channel_a_irq_oe,
    output channel_b_irq, channel_b_irq_oe
  );

  modport host (
    output bus_style, read_strobe_n, write_strobe_n, channel_a_select_n,
    output channel_b_select_n, addr, host_data, host_data_oe,
    input  data_line, irq_a_line, irq_b_line
  );
endinterface

/* src/duart_consts.svh */
`ifndef DUART_CONSTS_SVH
`define DUART_CONSTS_SVH

// Bus widths.
`define DUART_ADDR_W        3
`define DUART_DATA_W        8
`define DUART_CHANNELS      2

// Register slots inside a channel.
`define DUART_REG_MODEM     3'h4
`define DUART_MODEM_IRQ_EN  3
`define DUART_REG_PWR       3'h7

// Power control register fields (channel A, slot 7).
`define DUART_PWR_OSC       0
`define DUART_PWR_PUMP      1
`define DUART_PWR_SAVE      2
`define DUART_PWR_WAKE      7

// Reset values.
`define DUART_REG_RESET     8'h00
`define DUART_PWR_RESET     8'h00
`define DUART_PIN_RESET     20'hf8000

// Host strobe timing in core clock cycles.
`define DUART_SETUP_CYC     1
`define DUART_STROBE_CYC    6
`define DUART_HOLD_CYC      3

`endif

/* src/duart_device_port.sv */
`timescale 1ns/1ps
`include "duart_consts.svh"

// How it works
// - Three address lines pick one of eight.
// - Eight-bit data bus, device drives only reads.
// - Strap high selects separate read/write strobes.
// - Read strobe fall starts read, byte driven.
// - Write strobe rise latches host byte.
// - Strap low: write strobe becomes direction.
// - Strap low: read strobe ignored entirely.
// - Strap high: one select per channel.
// - Strap low: channel A select covers both.
// - Strap low: channel B select picks channel.
// - Strap high: one high interrupt per channel.
// - Strap high: interrupt driven only while control bit set.
// - Strap low: shared open-drain low interrupt.
// - Host keeps control bit three at zero.
// - Strap low: channel B interrupt unused.
// - Four power modes, active after reset.
// - Each mode reachable by pin or register.
// - Partial stops one source, full both.
// - Power-save while sleeping ignores the bus.
// - Leaving low power raises wake interrupt.
module duart_device_port
  import duart_pkg::*;
(
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_SRST,
  duart_bus_if.dev               bus,
  input  wire logic [1:0]        I_CHANNEL_IRQ,
  input  wire logic              I_SLEEP_OSC,
  input  wire logic              I_SLEEP_PUMP,
  input  wire logic              I_POWER_SAVE,
  input  wire logic              I_WAKE,
  output logic                   O_OSC_STOP,
  output logic                   O_PUMP_STOP,
  output duart_pkg::power_mode_e O_POWER_MODE,
  output logic                   O_WAKE_IRQ,
  output logic                   O_REG_WRITE,
  output logic                   O_REG_CHANNEL,
  output duart_pkg::reg_addr_t   O_REG_ADDR,
  output duart_pkg::byte_t       O_REG_WDATA
);
  import duart_pkg::*;

  localparam int PIN_W = 20;

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins;
  logic             sep_style;
  logic             rd_n;
  logic             wr_n;
  logic             cs_a_n;
  logic             cs_b_n;
  reg_addr_t        addr_s;
  byte_t            data_s;
  logic             hw_osc;
  logic             hw_pump;
  logic             hw_save;
  logic             hw_wake;

  byte_t            regs [`DUART_CHANNELS][8];
  byte_t            pwr_ctrl;
  power_mode_e      mode;
  power_mode_e      next_mode;
  logic             wake_flag;
  logic             isolate;
  logic             strobe;
  logic             strobe_q;
  logic             sel;
  logic             start;
  logic             finish;
  logic             cycle_open;
  logic             cyc_ok;
  logic             cyc_write;
  logic             cyc_chan;
  reg_addr_t        cyc_addr;
  logic             start_chan;
  logic             do_write;
  logic             pwr_read;
  logic             sleep_osc;
  logic             sleep_pump;
  logic             sleep_save;
  logic [1:0]       pend;

  function automatic logic is_pwr(input logic chan, input reg_addr_t a);
    return (chan == 1'h0) && (a == `DUART_REG_PWR);
  endfunction

  assign pins_raw = {bus.bus_style, bus.read_strobe_n, bus.write_strobe_n,
                     bus.channel_a_select_n, bus.channel_b_select_n, bus.addr,
                     bus.data_line, I_SLEEP_OSC, I_SLEEP_PUMP, I_POWER_SAVE, I_WAKE};

  duart_pin_sync #(
    .WIDTH     (PIN_W),
    .RESET_VAL (`DUART_PIN_RESET)
  ) u_sync (
    .i_clk   (I_CORE_CLK),
    .i_srst  (I_SRST),
    .i_async (pins_raw),
    .o_sync  (pins)
  );

  assign {sep_style, rd_n, wr_n, cs_a_n, cs_b_n, addr_s, data_s,
          hw_osc, hw_pump, hw_save, hw_wake} = pins;

  // Bus isolation only applies while the part is actually asleep.
  assign isolate = (mode == PWR_SAVE);

  // One strobe and one select per style; the read strobe is left out of
  // the read/write-line style altogether.
  assign strobe = ~isolate & (sep_style ? (~rd_n | ~wr_n)
                                        : ~cs_a_n);
  assign sel    = ~isolate & (sep_style ? (~cs_a_n | ~cs_b_n)
                                        : ~cs_a_n);
  assign start  = strobe & ~strobe_q;
  assign finish = ~strobe & strobe_q;
  // Separate style: select A low means channel A, otherwise B.
  assign start_chan = sep_style ? cs_a_n : cs_b_n;
  assign do_write = finish & cycle_open & cyc_ok & cyc_write & ~isolate;
  assign pwr_read = start & sel & wr_n & is_pwr(start_chan, addr_s);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      strobe_q   <= 1'h0;
      cycle_open <= 1'h0;
      cyc_ok     <= 1'h0;
      cyc_write  <= 1'h0;
      cyc_chan   <= 1'h0;
      cyc_addr   <= 3'h0;
    end else begin
      strobe_q <= strobe;
      if (start) begin
        cycle_open <= 1'h1;
        cyc_ok     <= sel;
        cyc_write  <= ~wr_n;
        cyc_chan   <= start_chan;
        cyc_addr   <= addr_s;
      end else if (finish) begin
        cycle_open <= 1'h0;
      end else if (cycle_open && !sel) begin
        cyc_ok     <= 1'h0;
      end
    end
  end

  // Read byte is fetched at the strobe's leading edge and held for the pulse.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      bus.dev_data <= `DUART_REG_RESET;
    end else if (start && sel && wr_n) begin
      if (is_pwr(start_chan, addr_s)) begin
        bus.dev_data <= pwr_ctrl | ({7'h0, wake_flag} << `DUART_PWR_WAKE);
      end else begin
        bus.dev_data <= regs[start_chan][addr_s];
      end
    end
  end

  assign bus.dev_data_oe = cycle_open & cyc_ok & ~cyc_write & sel;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      for (int c = 0; c < `DUART_CHANNELS; c++) begin
        for (int r = 0; r < 8; r++) begin
          regs[c][r] <= `DUART_REG_RESET;
        end
      end
    end else if (do_write && !is_pwr(cyc_chan, cyc_addr)) begin
      regs[cyc_chan][cyc_addr] <= data_s;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_REG_WRITE   <= 1'h0;
      O_REG_CHANNEL <= 1'h0;
      O_REG_ADDR    <= 3'h0;
      O_REG_WDATA   <= `DUART_REG_RESET;
    end else begin
      O_REG_WRITE <= do_write;
      if (do_write) begin
        O_REG_CHANNEL <= cyc_chan;
        O_REG_ADDR    <= cyc_addr;
        O_REG_WDATA   <= data_s;
      end
    end
  end

  // Software sleep bits; a hardware wake clears them, since a bus that is
  // isolated cannot be used to leave power-save.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      pwr_ctrl <= `DUART_PWR_RESET;
    end else if (hw_wake) begin
      pwr_ctrl <= `DUART_PWR_RESET;
    end else if (do_write && is_pwr(cyc_chan, cyc_addr)) begin
      pwr_ctrl <= data_s & 8'h07;
    end
  end

  assign sleep_osc  = hw_osc  | pwr_ctrl[`DUART_PWR_OSC];
  assign sleep_pump = hw_pump | pwr_ctrl[`DUART_PWR_PUMP];
  assign sleep_save = hw_save | pwr_ctrl[`DUART_PWR_SAVE];

  always_comb begin
    if (sleep_osc && sleep_pump) begin
      next_mode = sleep_save ? PWR_SAVE : PWR_FULL;
    end else if (sleep_osc || sleep_pump) begin
      next_mode = sleep_save ? PWR_SAVE : PWR_PARTIAL;
    end else begin
      next_mode = PWR_ACTIVE;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      mode        <= PWR_ACTIVE;
      O_OSC_STOP  <= 1'h0;
      O_PUMP_STOP <= 1'h0;
    end else begin
      mode        <= next_mode;
      O_OSC_STOP  <= sleep_osc;
      O_PUMP_STOP <= sleep_pump;
    end
  end

  assign O_POWER_MODE = mode;

  // Wake flag: a new wake in the same cycle as the clearing read wins.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      wake_flag <= 1'h0;
    end else if (mode != PWR_ACTIVE && next_mode == PWR_ACTIVE) begin
      wake_flag <= 1'h1;
    end else if (pwr_read) begin
      wake_flag <= 1'h0;
    end
  end

  assign O_WAKE_IRQ = wake_flag;
  assign pend = {I_CHANNEL_IRQ[1], I_CHANNEL_IRQ[0] | wake_flag};

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      bus.channel_a_irq    <= 1'h0;
      bus.channel_a_irq_oe <= 1'h0;
      bus.channel_b_irq    <= 1'h0;
      bus.channel_b_irq_oe <= 1'h0;
    end else if (sep_style) begin
      bus.channel_a_irq    <= pend[0];
      bus.channel_a_irq_oe <= regs[0][`DUART_REG_MODEM][`DUART_MODEM_IRQ_EN];
      bus.channel_b_irq    <= pend[1];
      bus.channel_b_irq_oe <= regs[1][`DUART_REG_MODEM][`DUART_MODEM_IRQ_EN];
    end else begin
      bus.channel_a_irq    <= 1'h0;
      bus.channel_a_irq_oe <= |pend;
      bus.channel_b_irq    <= 1'h0;
      bus.channel_b_irq_oe <= 1'h0;
    end
  end
endmodule // duart_device_port

/* src/duart_host_port.sv */
`timescale 1ns/1ps
`include "duart_consts.svh"

module duart_host_port
  import duart_pkg::*;
#(
  parameter int SETUP_CYC  = `DUART_SETUP_CYC,
  parameter int STROBE_CYC = `DUART_STROBE_CYC,
  parameter int HOLD_CYC   = `DUART_HOLD_CYC
) (
  input  wire logic            I_CORE_CLK,
  input  wire logic            I_SRST,
  duart_bus_if.host            bus,
  input  wire logic            I_BUS_STYLE,
  input  wire logic            I_REQ,
  input  wire logic            I_WRITE,
  input  wire logic            I_CHANNEL,
  input  duart_pkg::reg_addr_t I_ADDR,
  input  duart_pkg::byte_t     I_WDATA,
  output logic                 O_READY,
  output logic                 O_DONE,
  output duart_pkg::byte_t     O_RDATA,
  output logic                 O_IRQ_A,
  output logic                 O_IRQ_B
);
  import duart_pkg::*;

  host_state_e state;
  logic [3:0]  count;
  logic        write_q;
  logic        sep;

  if (SETUP_CYC < 1 || SETUP_CYC > 15) begin : g_bad_setup
    $error("duart_host_port: bad SETUP_CYC");
  end
  if (STROBE_CYC < 4 || STROBE_CYC > 15) begin : g_bad_strobe
    $error("duart_host_port: bad STROBE_CYC");
  end
  if (HOLD_CYC < 3 || HOLD_CYC > 15) begin : g_bad_hold
    $error("duart_host_port: bad HOLD_CYC");
  end

  assign O_READY = (state == HOST_IDLE);
  assign sep     = bus.bus_style;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      state                  <= HOST_IDLE;
      count                  <= 4'h0;
      write_q                <= 1'h0;
      O_DONE                 <= 1'h0;
      O_RDATA                <= 8'h00;
      bus.bus_style          <= 1'h1;
      bus.read_strobe_n      <= 1'h1;
      bus.write_strobe_n     <= 1'h1;
      bus.channel_a_select_n <= 1'h1;
      bus.channel_b_select_n <= 1'h1;
      bus.addr               <= 3'h0;
      bus.host_data          <= 8'h00;
      bus.host_data_oe       <= 1'h0;
    end else begin
      O_DONE <= 1'h0;
      count  <= count + 4'h1;
      unique case (state)
        HOST_IDLE: begin
          bus.bus_style <= I_BUS_STYLE;
          if (I_REQ) begin
            state            <= HOST_SETUP;
            count            <= 4'h1;
            write_q          <= I_WRITE;
            bus.addr         <= I_ADDR;
            bus.host_data    <= I_WDATA;
            bus.host_data_oe <= I_WRITE;
            if (sep) begin
              bus.channel_a_select_n <= I_CHANNEL;
              bus.channel_b_select_n <= ~I_CHANNEL;
            end else begin
              bus.write_strobe_n     <= ~I_WRITE;
              bus.channel_b_select_n <= I_CHANNEL;
            end
          end
        end
        HOST_SETUP: begin
          if (count == 4'(SETUP_CYC)) begin
            state <= HOST_STROBE;
            count <= 4'h1;
            if (!sep) begin
              bus.channel_a_select_n <= 1'h0;
            end else if (write_q) begin
              bus.write_strobe_n <= 1'h0;
            end else begin
              bus.read_strobe_n <= 1'h0;
            end
          end
        end
        HOST_STROBE: begin
          if (count == 4'(STROBE_CYC)) begin
            state <= HOST_HOLD;
            count <= 4'h1;
            if (!write_q) begin
              O_RDATA <= bus.data_line;
            end
            bus.read_strobe_n <= 1'h1;
            if (sep) begin
              bus.write_strobe_n <= 1'h1;
            end else begin
              bus.channel_a_select_n <= 1'h1;
            end
          end
        end
        HOST_HOLD: begin
          if (count == 4'(HOLD_CYC)) begin
            state                  <= HOST_IDLE;
            O_DONE                 <= 1'h1;
            bus.write_strobe_n     <= 1'h1;
            bus.channel_a_select_n <= 1'h1;
            bus.channel_b_select_n <= 1'h1;
            bus.host_data_oe       <= 1'h0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      O_IRQ_A <= 1'h0;
      O_IRQ_B <= 1'h0;
    end else begin
      O_IRQ_A <= sep ? bus.irq_a_line : ~bus.irq_a_line;
      O_IRQ_B <= sep ? bus.irq_b_line : 1'h0;
    end
  end
endmodule // duart_host_port

/* src/duart_pin_sync.sv */
`timescale 1ns/1ps
module duart_pin_sync #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  if (WIDTH < 1) begin : g_bad_width
    $error("duart_pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta   <= RESET_VAL;
      o_sync <= RESET_VAL;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // duart_pin_sync

/* src/duart_pkg.sv */
package duart_pkg;

  typedef enum logic [3:0] {
    PWR_ACTIVE  = 4'b0001,
    PWR_PARTIAL = 4'b0010,
    PWR_FULL    = 4'b0100,
    PWR_SAVE    = 4'b1000
  } power_mode_e;

  typedef enum logic [3:0] {
    HOST_IDLE   = 4'b0001,
    HOST_SETUP  = 4'b0010,
    HOST_STROBE = 4'b0100,
    HOST_HOLD   = 4'b1000
  } host_state_e;

  typedef logic [7:0] byte_t;
  typedef logic [2:0] reg_addr_t;

endpackage
